// [dio_host_port.sv]
// Purpose: Asynchronous 8-bit host register access port
// Assumes: Host pins asynchronous to mclk_i; external pull-up on ready
// Notes: Output enables are active low (low means driving)
`timescale 1ns/100ps
`include "dio_defines.svh"

module dio_host_port (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Host request pins
   input wire dio_pkg::dio_req_t host_req_i,
   input wire logic host_select_n_i,
   // Host data bus
   output logic [`DIO_DATA_W-1:0] host_data_o,
   output logic host_data_oe_n_o,
   // Host ready strobe
   output logic host_ready_n_o,
   output logic host_ready_oe_n_o
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [2:0] sel_sync_reg;
   logic [2:0] sel_sync_next;
   logic sel_low_reg;
   logic sel_low_next;
   dio_pkg::dio_req_t req_s1_reg;
   dio_pkg::dio_req_t req_s2_reg;
   dio_pkg::dio_req_t req_s3_reg;
   dio_pkg::dio_req_t req_hold_reg;
   dio_pkg::dio_req_t req_hold_next;

   always_comb begin
      sel_sync_next = {sel_sync_reg[1:0], host_select_n_i};
      sel_low_next = sel_low_reg;
      req_hold_next = req_hold_reg;
      if (sel_sync_reg[1] == sel_sync_reg[2]) begin
         sel_low_next = !sel_sync_reg[2];
      end
      if (req_s2_reg == req_s3_reg) begin
         req_hold_next = req_s3_reg;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sel_sync_reg <= `DIO_SYNC_RST;
         sel_low_reg <= 1'b0;
         req_s1_reg <= '0;
         req_s2_reg <= '0;
         req_s3_reg <= '0;
         req_hold_reg <= '0;
      end else begin
         sel_sync_reg <= sel_sync_next;
         sel_low_reg <= sel_low_next;
         req_s1_reg <= host_req_i;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
         req_hold_reg <= req_hold_next;
      end
   end

   // ----------------------------------------
   // Access sequencer
   // ----------------------------------------
   dio_pkg::dio_state_t state_reg;
   dio_pkg::dio_state_t state_next;
   logic rd_mode_reg;
   logic rd_mode_next;
   logic wr_en;
   logic rd_en;
   logic [`DIO_DATA_W-1:0] rdata;
   logic [`DIO_DATA_W-1:0] data_out_reg;
   logic [`DIO_DATA_W-1:0] data_out_next;
   logic data_oe_n_reg;
   logic data_oe_n_next;
   logic ready_n_reg;
   logic ready_n_next;
   logic ready_oe_n_reg;
   logic ready_oe_n_next;

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   function automatic logic access_start(input logic sel_low, input logic rnw,
         input logic want_read);
      return sel_low && (rnw == want_read);
   endfunction

   always_comb begin
      state_next = state_reg;
      rd_mode_next = rd_mode_reg;
      data_out_next = data_out_reg;
      data_oe_n_next = data_oe_n_reg;
      ready_n_next = ready_n_reg;
      ready_oe_n_next = ready_oe_n_reg;
      wr_en = 1'b0;
      rd_en = 1'b0;
      case (state_reg)
         dio_pkg::DIO_IDLE: begin
            ready_n_next = 1'b1;
            ready_oe_n_next = 1'b1;
            data_oe_n_next = 1'b1;
            if (access_start(sel_low_reg, req_hold_reg.read_not_write, 1'b0)) begin
               wr_en = 1'b1;
               rd_mode_next = 1'b0;
               state_next = dio_pkg::DIO_WR_ACK;
            end else if (access_start(sel_low_reg, req_hold_reg.read_not_write, 1'b1)) begin
               rd_en = 1'b1;
               rd_mode_next = 1'b1;
               data_oe_n_next = 1'b0;
               state_next = dio_pkg::DIO_RD_DRIVE;
            end
         end
         dio_pkg::DIO_WR_ACK: begin
            ready_n_next = 1'b0;
            ready_oe_n_next = 1'b0;
            if (!sel_low_reg) begin
               ready_n_next = 1'b1;
               state_next = dio_pkg::DIO_RELEASE;
            end else begin
               state_next = dio_pkg::DIO_RD_ACK;
            end
         end
         dio_pkg::DIO_RD_DRIVE: begin
            data_out_next = rdata;
            state_next = dio_pkg::DIO_RD_ACK;
         end
         dio_pkg::DIO_RD_ACK: begin
            ready_n_next = 1'b0;
            ready_oe_n_next = 1'b0;
            if (!sel_low_reg) begin
               ready_n_next = 1'b1;
               data_oe_n_next = 1'b1;
               state_next = dio_pkg::DIO_RELEASE;
            end
         end
         dio_pkg::DIO_RELEASE: begin
            ready_oe_n_next = 1'b1;
            ready_n_next = 1'b1;
            state_next = dio_pkg::DIO_IDLE;
         end
         default: begin
            state_next = dio_pkg::DIO_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state_reg <= dio_pkg::DIO_IDLE;
         rd_mode_reg <= 1'b0;
         data_out_reg <= `DIO_REG_RST;
         data_oe_n_reg <= 1'b1;
         ready_n_reg <= 1'b1;
         ready_oe_n_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         rd_mode_reg <= rd_mode_next;
         data_out_reg <= data_out_next;
         data_oe_n_reg <= data_oe_n_next;
         ready_n_reg <= ready_n_next;
         ready_oe_n_reg <= ready_oe_n_next;
      end
   end

   // ----------------------------------------
   // Register store
   // ----------------------------------------
   dio_regfile u_regs (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .wr_en_i(wr_en),
      .rd_en_i(rd_en),
      .addr_i(req_hold_reg.reg_addr),
      .wdata_i(req_hold_reg.wdata),
      .rdata_o(rdata)
   );

   assign host_data_o = data_out_reg;
   assign host_data_oe_n_o = data_oe_n_reg;
   assign host_ready_n_o = ready_n_reg;
   assign host_ready_oe_n_o = ready_oe_n_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_rdy_after_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      wr_en |-> ##2 (!host_ready_n_o && !host_ready_oe_n_o))
      else $error("ready not low after write capture");
   a_rdy_high_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $rose(host_ready_n_o) |-> !host_ready_oe_n_o ##1 host_ready_oe_n_o)
      else $error("ready high not one cycle before release");
   a_data_before_rdy: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (rd_mode_reg && $fell(host_ready_n_o)) |-> !host_data_oe_n_o)
      else $error("ready low without data driven");
   a_read_drives: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      rd_en |=> !host_data_oe_n_o)
      else $error("data bus not driven after read start");
   a_read_release: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (state_reg == dio_pkg::DIO_RELEASE) |-> host_data_oe_n_o)
      else $error("data bus still driven after read");
   a_write_start: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      wr_en |=> u_regs.mem_reg[$past(req_hold_reg.reg_addr)] == $past(req_hold_reg.wdata))
      else $error("write value not stored");
   a_sel_filter: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $fell(sel_low_reg) |-> $past(sel_sync_reg[2]) && $past(sel_sync_reg[1]))
      else $error("select change without agreement");
   a_idle_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (state_reg == dio_pkg::DIO_IDLE) |-> host_ready_oe_n_o ##0 host_data_oe_n_o)
      else $error("pins driven while idle");
   a_sel_settle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $rose(sel_low_reg) |-> !$past(sel_sync_reg[2]) && !$past(sel_sync_reg[1]))
      else $error("select taken before stages agree");
   a_ack_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (state_reg == dio_pkg::DIO_RD_ACK && sel_low_reg) |=> !host_ready_n_o)
      else $error("ready not held low while selected");
   a_read_value: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (rd_mode_reg && $fell(host_ready_n_o)) |-> host_data_o == u_regs.mem_reg[req_hold_reg.reg_addr])
      else $error("read data differs from register");
   a_ready_high_drive: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (state_reg == dio_pkg::DIO_RELEASE) |-> host_ready_n_o && !host_ready_oe_n_o)
      else $error("ready not driven high before release");

endmodule

// [dio_defines.svh]
// Purpose: Constants for the direct I/O host port
// Assumes: Core clock 125 MHz, host side has no clock
// Notes: Widths, register count and reset values as macros
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// ----------------------------------------
// Widths and register count
// ----------------------------------------
`define DIO_ADDR_W 2
`define DIO_DATA_W 8
`define DIO_NUM_REGS 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DIO_REG_RST 8'h00
`define DIO_SYNC_RST 3'h7

`endif

// [dio_pkg.sv]
// Purpose: Types for the direct I/O host port
// Assumes: dio_defines.svh included
// Notes: Packed carriers for host pins
`include "dio_defines.svh"

package dio_pkg;

   // ----------------------------------------
   // Host request pins
   // ----------------------------------------
   typedef struct packed {
      logic [`DIO_ADDR_W-1:0] reg_addr;
      logic read_not_write;
      logic [`DIO_DATA_W-1:0] wdata;
   } dio_req_t;

   // ----------------------------------------
   // Port states
   // ----------------------------------------
   typedef enum logic [2:0] {
      DIO_IDLE,
      DIO_WR_ACK,
      DIO_RD_DRIVE,
      DIO_RD_ACK,
      DIO_RELEASE
   } dio_state_t;

endpackage

// [dio_regfile.sv]
// Purpose: Host-visible register store
// Assumes: Single clock, synchronous active-low reset
// Notes: Read data comes from a register
`timescale 1ns/100ps
`include "dio_defines.svh"

module dio_regfile (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Access
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [`DIO_ADDR_W-1:0] addr_i,
   input wire logic [`DIO_DATA_W-1:0] wdata_i,
   output logic [`DIO_DATA_W-1:0] rdata_o
);

   logic [`DIO_DATA_W-1:0] mem_reg [`DIO_NUM_REGS];
   logic [`DIO_DATA_W-1:0] mem_next [`DIO_NUM_REGS];
   logic [`DIO_DATA_W-1:0] rdata_reg;
   logic [`DIO_DATA_W-1:0] rdata_next;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      mem_next = mem_reg;
      rdata_next = rdata_reg;
      if (wr_en_i) begin
         mem_next[addr_i] = wdata_i;
      end
      if (rd_en_i) begin
         rdata_next = mem_reg[addr_i];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < `DIO_NUM_REGS; i++) begin
            mem_reg[i] <= `DIO_REG_RST;
         end
         rdata_reg <= `DIO_REG_RST;
      end else begin
         mem_reg <= mem_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

endmodule

// [dio_host_model.sv]
// Purpose: Host microprocessor model for the direct I/O host port
// Assumes: Pull-up on ready; request pins change 1 ns after a clock edge
// Notes: Released data lines show the inverse of the last driven value
`timescale 1ns/100ps
`include "dio_defines.svh"

module dio_host_model (
   // Clock
   input wire logic mclk_i,
   // Host request pins
   output dio_pkg::dio_req_t host_req_o,
   output logic host_select_n_o,
   // Device pins
   input wire logic [`DIO_DATA_W-1:0] host_data_i,
   input wire logic host_data_oe_n_i,
   input wire logic host_ready_n_i,
   input wire logic host_ready_oe_n_i
);
   logic [`DIO_DATA_W-1:0] last_reg;
   logic [`DIO_DATA_W-1:0] bus;
   logic rdy_n;

   // ----------------------------------------
   // Wire levels
   // ----------------------------------------
   assign rdy_n = host_ready_oe_n_i ? 1'b1 : host_ready_n_i;
   assign bus = host_data_oe_n_i ? ~last_reg : host_data_i;
   always @(posedge mclk_i) begin
      if (!host_data_oe_n_i) last_reg <= host_data_i;
   end

   initial begin
      host_req_o = '0;
      host_req_o.read_not_write = 1'b1;
      host_select_n_o = 1'b1;
      last_reg = '0;
   end

   // ----------------------------------------
   // One access, called 1 ns after a clock edge
   // ----------------------------------------
   task automatic access(input logic rnw, input logic [1:0] addr, input logic [7:0] wd,
         output logic [7:0] rd, output logic de_n, output int hi);
      int i;
      host_req_o.reg_addr = addr;
      host_req_o.read_not_write = rnw;
      host_req_o.wdata = wd;
      repeat (3) @(posedge mclk_i);
      #1 host_select_n_o = 1'b0;
      for (i = 0; i < 30 && rdy_n !== 1'b0; i++) begin
         @(posedge mclk_i);
         #1;
      end
      rd = bus;
      de_n = host_data_oe_n_i;
      host_req_o.reg_addr = ~addr;
      host_req_o.wdata = ~wd;
      @(posedge mclk_i);
      #1 host_select_n_o = 1'b1;
      hi = 0;
      for (i = 0; i < 30 && host_ready_oe_n_i !== 1'b1; i++) begin
         @(posedge mclk_i);
         #1;
         if (host_ready_oe_n_i === 1'b0 && host_ready_n_i === 1'b1) hi++;
      end
      repeat (2) @(posedge mclk_i);
      #1;
   endtask
endmodule

// [dio_host_port_tb.sv]
// Purpose: Self-checking bench for the direct I/O host port
// Assumes: Host model drives the request pins
// Notes: Table of accesses, then reset in mid-run
`timescale 1ns/100ps

module dio_host_port_tb;
   typedef struct packed {
      logic rnw;
      logic [1:0] addr;
      logic [7:0] wd;
      logic [7:0] exp;
   } dio_row_t;

   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   dio_pkg::dio_req_t host_req;
   logic host_select_n;
   logic [7:0] host_data_o;
   logic host_data_oe_n_o;
   logic host_ready_n_o;
   logic host_ready_oe_n_o;
   int num_errors = 0;
   int tests_run = 0;
   logic [7:0] rd;
   logic de_n;
   int hi;
   dio_row_t rows [10] = '{
      '{1'b0, 2'h0, 8'hA5, 8'h00}, '{1'b0, 2'h1, 8'h5A, 8'h00},
      '{1'b0, 2'h2, 8'hFF, 8'h00}, '{1'b0, 2'h3, 8'hC3, 8'h00},
      '{1'b1, 2'h0, 8'h00, 8'hA5}, '{1'b1, 2'h1, 8'h00, 8'h5A},
      '{1'b1, 2'h2, 8'h00, 8'hFF}, '{1'b1, 2'h3, 8'h00, 8'hC3},
      '{1'b0, 2'h1, 8'h3C, 8'h00}, '{1'b1, 2'h1, 8'h00, 8'h3C}};

   always #4 mclk_i = ~mclk_i;

   dio_host_port uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .host_req_i(host_req),
      .host_select_n_i(host_select_n), .host_data_o(host_data_o),
      .host_data_oe_n_o(host_data_oe_n_o), .host_ready_n_o(host_ready_n_o),
      .host_ready_oe_n_o(host_ready_oe_n_o));

   dio_host_model hp (.mclk_i(mclk_i), .host_req_o(host_req), .host_select_n_o(host_select_n),
      .host_data_i(host_data_o), .host_data_oe_n_i(host_data_oe_n_o),
      .host_ready_n_i(host_ready_n_o), .host_ready_oe_n_i(host_ready_oe_n_o));

   // ----------------------------------------
   // Compare and close
   // ----------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #(8 * 3000);
      num_errors++;
      wrap_up();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge mclk_i);
      #1 rst_b_i = 1'b1;
      check("idle enables", {6'h00, host_data_oe_n_o, host_ready_oe_n_o}, 8'h03);
      foreach (rows[k]) begin
         hp.access(rows[k].rnw, rows[k].addr, rows[k].wd, rd, de_n, hi);
         if (rows[k].rnw) check("read data", rd, rows[k].exp);
         check("data enable at ready", {7'h00, de_n}, {7'h00, ~rows[k].rnw});
         check("ready high cycles", 8'(hi), 8'h01);
         check("data released", {7'h00, host_data_oe_n_o}, 8'h01);
      end
      rst_b_i = 1'b0;
      repeat (4) @(posedge mclk_i);
      #1 check("reset enables", {6'h00, host_data_oe_n_o, host_ready_oe_n_o}, 8'h03);
      rst_b_i = 1'b1;
      hp.access(1'b1, 2'h2, 8'h00, rd, de_n, hi);
      check("read after reset", rd, 8'h00);
      check("ready high after reset", 8'(hi), 8'h01);
      wrap_up();
   end
endmodule
